// file: hw/fsrr_pkg.sv
// Purpose: constants for the suspend/resume and read command interpreter
// Assumes: 10 MHz ref_clk, host serial clock well below it
// Notes: opcodes, field places, dummy counts and timing live here
package fsrr_pkg;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_DTR = 8'h0D;
   localparam logic [7:0] OP_DUAL = 8'h3B;
   localparam logic [7:0] OP_QUAD = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_SET_PARAM = 8'hC0;
   localparam logic [7:0] OP_WRSR_A = 8'h01;
   localparam logic [7:0] OP_WRSR_B = 8'h31;
   localparam logic [7:0] OP_WRSR_C = 8'h11;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_QPROG = 8'h32;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;
   localparam logic [7:0] OP_SECT_ERASE = 8'h20;
   localparam logic [7:0] OP_HALF_ERASE = 8'h52;
   localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_NONE = 8'h00;
   // kind of self-timed operation the engine is running
   localparam logic [2:0] KIND_NONE = 3'h0;
   localparam logic [2:0] KIND_SECTOR = 3'h1;
   localparam logic [2:0] KIND_BLOCK = 3'h2;
   localparam logic [2:0] KIND_PAGE = 3'h3;
   localparam logic [2:0] KIND_CHIP = 3'h4;
   localparam logic [2:0] KIND_SECREG = 3'h5;
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h18;
   localparam logic [5:0] PARAM_BITS = 6'h08;
   localparam int SECT_MSB = 23;
   localparam int SECT_LSB = 12;
   localparam int PARAM_DUMMY_MSB = 5;
   localparam int PARAM_DUMMY_LSB = 4;
   localparam logic [1:0] PARAM_DUMMY_RST = 2'h0;
   localparam logic [5:0] DUMMY_FAST = 6'h08;
   localparam logic [5:0] DUMMY_DTR = 6'h06;
   localparam logic [5:0] DUMMY_DTR_QPI = 6'h08;
   localparam logic [5:0] DUMMY_DUAL = 6'h08;
   localparam logic [5:0] DUMMY_QUAD = 6'h08;
   localparam logic [5:0] DUMMY_DUAL_IO = 6'h04;
   localparam logic [5:0] DUMMY_QPI_4 = 6'h04;
   localparam logic [5:0] DUMMY_QPI_6 = 6'h06;
   localparam logic [5:0] DUMMY_QPI_8 = 6'h08;
   localparam int CLK_NS = 100;
   localparam int RESUME_BUSY_NS = 200;
   localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS / CLK_NS < 1) ? 1 :
      RESUME_BUSY_NS / CLK_NS;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_OPC = 7'h02,
      ST_ADDR = 7'h04,
      ST_DUMMY = 7'h08,
      ST_DATA = 7'h10,
      ST_HOLD = 7'h20,
      ST_IGN = 7'h40
   } fsrr_state_type;
endpackage

// file: hw/fsrr_cmd.sv
// Purpose: serial flash suspend/resume and array read command interpreter
// Assumes: link pins sampled by ref_clk; array answers within one cycle
// Notes: write/erase/program headers are passed on to the engine, gated
`timescale 1ns/1ps
`default_nettype none
module fsrr_cmd
   import fsrr_pkg::*;
#(
   parameter int SUS_LAT_NS = 20000
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   output logic [23:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic quad_io_enable_bit,
   input wire logic quad_command_mode,
   input wire logic engine_running,
   input wire logic [2:0] op_kind,
   input wire logic [23:0] op_addr,
   output logic suspend_req,
   output logic resume_req,
   output logic suspend_status_flag,
   output logic busy,
   output logic cmd_valid,
   output logic cmd_refused,
   output logic [7:0] cmd_opcode,
   output logic [23:0] cmd_addr,
   output logic [1:0] dummy_count_field
);
   localparam int SUS_LAT_CYC = (SUS_LAT_NS / CLK_NS < 1) ? 1 :
      SUS_LAT_NS / CLK_NS;
   localparam int CHK_LAT = SUS_LAT_CYC + 2;
   localparam int CHK_RES = RESUME_BUSY_CYC;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] cs_s_q;
   logic [1:0] ck_s_q;
   logic [3:0] io_s1_q;
   logic [3:0] io_s2_q;
   logic cs_d_q;
   logic ck_d_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cs_s_q <= 2'h3;
         ck_s_q <= 2'h0;
         io_s1_q <= 4'h0;
         io_s2_q <= 4'h0;
         cs_d_q <= 1'b1;
         ck_d_q <= 1'b0;
      end else begin
         cs_s_q <= {cs_s_q[0], cs_n_pin};
         ck_s_q <= {ck_s_q[0], sclk_pin};
         io_s1_q <= io_in;
         io_s2_q <= io_s1_q;
         cs_d_q <= cs_s_q[1];
         ck_d_q <= ck_s_q[1];
      end
   end

   logic sel;
   logic cs_up;
   logic rise;
   logic fall;
   assign sel = ~cs_s_q[1];
   assign cs_up = cs_s_q[1] & ~cs_d_q;
   assign rise = ck_s_q[1] & ~ck_d_q;
   assign fall = ~ck_s_q[1] & ck_d_q;

   ////////////////////////////////////////////////////////////////////
   // command decode
   fsrr_state_type state_q;
   logic [5:0] cnt_q;
   logic [23:0] sh_q;
   logic [7:0] opc_q;
   logic [2:0] in_w_q;
   logic [2:0] out_w_q;
   logic [5:0] dum_q;
   logic dtr_q;
   logic busy_q;
   logic sus_q;

   logic in_edge;
   logic [23:0] sh_nxt;
   logic [5:0] cnt_nxt;
   logic [7:0] opc_nxt;
   logic rd_ok;
   logic rd_dtr;
   logic [2:0] rd_ain;
   logic [2:0] rd_out;
   logic [5:0] rd_dummy;
   logic [5:0] qpi_dummy;
   logic [2:0] base_w;

   // double-rate address takes both edges
   assign in_edge = rise | (dtr_q & fall & (state_q == ST_ADDR));
   assign cnt_nxt = cnt_q + {3'h0, in_w_q};
   assign opc_nxt = sh_nxt[7:0];
   assign base_w = quad_command_mode ? 3'h4 : 3'h1;

   always_comb begin
      case (in_w_q)
         3'h4: sh_nxt = {sh_q[19:0], io_s2_q};
         3'h2: sh_nxt = {sh_q[21:0], io_s2_q[1:0]};
         default: sh_nxt = {sh_q[22:0], io_s2_q[0]};
      endcase
   end

   always_comb begin
      case (dummy_count_field)
         2'h0: qpi_dummy = DUMMY_QPI_4;
         2'h1: qpi_dummy = DUMMY_QPI_6;
         default: qpi_dummy = DUMMY_QPI_8;
      endcase
   end

   always_comb begin
      rd_ok = 1'b1;
      rd_dtr = 1'b0;
      rd_ain = base_w;
      rd_out = base_w;
      rd_dummy = 6'h00;
      case (opc_nxt)
         OP_READ: rd_dummy = 6'h00;
         OP_FAST:
            rd_dummy = quad_command_mode ? qpi_dummy : DUMMY_FAST;
         OP_DTR: begin
            rd_dtr = 1'b1;
            rd_dummy = quad_command_mode ? DUMMY_DTR_QPI : DUMMY_DTR;
         end
         OP_DUAL: begin
            rd_ok = ~quad_command_mode;
            rd_out = 3'h2;
            rd_dummy = DUMMY_DUAL;
         end
         OP_QUAD: begin
            rd_ok = quad_io_enable_bit & ~quad_command_mode;
            rd_out = 3'h4;
            rd_dummy = DUMMY_QUAD;
         end
         OP_DUAL_IO: begin
            rd_ok = ~quad_command_mode;
            rd_ain = 3'h2;
            rd_out = 3'h2;
            rd_dummy = DUMMY_DUAL_IO;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   logic is_fwd;
   always_comb begin
      case (opc_nxt)
         OP_WRSR_A, OP_WRSR_B, OP_WRSR_C, OP_PROG, OP_QPROG,
         OP_SEC_PROG, OP_SECT_ERASE, OP_HALF_ERASE, OP_BLK_ERASE,
         OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SEC_ERASE,
         OP_SET_PARAM: is_fwd = 1'b1;
         default: is_fwd = 1'b0;
      endcase
   end

   logic opc_done;
   logic rd_busy_ign;
   assign opc_done = (state_q == ST_OPC) & in_edge & (cnt_nxt == OPC_BITS);
   assign rd_busy_ign = opc_done & rd_ok & busy_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= 6'h00;
         sh_q <= 24'h000000;
         opc_q <= OP_NONE;
         in_w_q <= 3'h1;
         out_w_q <= 3'h1;
         dum_q <= 6'h00;
         dtr_q <= 1'b0;
      end else if (!sel) begin
         state_q <= ST_IDLE;
         dtr_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_q <= ST_OPC;
               cnt_q <= 6'h00;
               opc_q <= OP_NONE;
               in_w_q <= base_w;
            end
            ST_OPC: begin
               if (in_edge) begin
                  sh_q <= sh_nxt;
                  cnt_q <= cnt_nxt;
               end
               if (opc_done) begin
                  opc_q <= opc_nxt;
                  cnt_q <= 6'h00;
                  in_w_q <= rd_ok ? rd_ain : in_w_q;
                  out_w_q <= rd_out;
                  dum_q <= rd_dummy;
                  dtr_q <= rd_ok & rd_dtr;
                  if (rd_busy_ign) begin
                     state_q <= ST_IGN;
                  end else if (rd_ok) begin
                     state_q <= ST_ADDR;
                  end else if (is_fwd) begin
                     state_q <= ST_HOLD;
                  end else begin
                     state_q <= ST_IGN;
                  end
               end
            end
            ST_ADDR: begin
               if (in_edge) begin
                  sh_q <= sh_nxt;
                  cnt_q <= cnt_nxt;
                  if (cnt_nxt == ADDR_BITS) begin
                     cnt_q <= 6'h00;
                     state_q <= (dum_q == 6'h00) ? ST_DATA : ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               // input lines are don't care here, only rises count
               if (rise) begin
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q + 6'h01 == dum_q) begin
                     state_q <= ST_DATA;
                  end
               end
            end
            ST_HOLD: begin
               // keep the header only; payload bytes belong to the engine
               if (in_edge && cnt_q < ADDR_BITS) begin
                  sh_q <= sh_nxt;
                  cnt_q <= cnt_nxt;
               end
            end
            ST_DATA, ST_IGN: state_q <= state_q;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read parameter byte
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dummy_count_field <= PARAM_DUMMY_RST;
      end else if (sel && state_q == ST_HOLD && opc_q == OP_SET_PARAM &&
                   in_edge && cnt_nxt == PARAM_BITS) begin
         dummy_count_field <= sh_nxt[PARAM_DUMMY_MSB:PARAM_DUMMY_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data path
   logic out_edge;
   logic addr_load;
   logic [2:0] obit_q;
   logic [7:0] osh_q;
   logic [7:0] o_word;

   assign out_edge = (state_q == ST_DATA) & (fall | (dtr_q & rise));
   assign addr_load = (state_q == ST_ADDR) & in_edge & (cnt_nxt == ADDR_BITS);
   assign o_word = (obit_q == 3'h0) ? mem_rdata : osh_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         io_out <= 4'h0;
         io_oe <= 4'h0;
         mem_addr <= 24'h000000;
         obit_q <= 3'h0;
         osh_q <= 8'h00;
      end else if (!sel) begin
         io_oe <= 4'h0;
         obit_q <= 3'h0;
      end else if (addr_load) begin
         mem_addr <= sh_nxt;
         obit_q <= 3'h0;
      end else if (out_edge) begin
         if (obit_q == 3'h0) begin
            mem_addr <= mem_addr + 24'h000001;
         end
         osh_q <= o_word << out_w_q;
         obit_q <= obit_q + out_w_q;
         // lines turn round only at the first data edge
         case (out_w_q)
            3'h4: begin
               io_out <= o_word[7:4];
               io_oe <= 4'hF;
            end
            3'h2: begin
               io_out <= {2'h0, o_word[7:6]};
               io_oe <= 4'h3;
            end
            default: begin
               io_out <= {2'h0, o_word[7], 1'b0};
               io_oe <= 4'h2;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // suspend, resume and command gating
   logic susp_erase_q;
   logic [SECT_MSB-SECT_LSB:0] sus_sect_q;
   logic [15:0] lat_cnt_q;
   logic lat_exp;
   logic res_pend_q;
   logic kind_ok;
   logic sus_ok;
   logic res_ok;
   logic op_wrsr;
   logic op_erase;
   logic op_prog;
   logic fwd_now;
   logic blocked;

   assign kind_ok = (op_kind == KIND_SECTOR) | (op_kind == KIND_BLOCK) |
      (op_kind == KIND_PAGE);
   assign sus_ok = cs_up & (opc_q == OP_SUSPEND) & ~sus_q & busy_q &
      kind_ok;
   assign res_ok = cs_up & (opc_q == OP_RESUME) & sus_q & ~busy_q;
   assign lat_exp = sus_q & (lat_cnt_q == 16'(SUS_LAT_CYC));

   assign op_wrsr = (opc_q == OP_WRSR_A) | (opc_q == OP_WRSR_B) |
      (opc_q == OP_WRSR_C);
   assign op_erase = (opc_q == OP_SECT_ERASE) | (opc_q == OP_HALF_ERASE) |
      (opc_q == OP_BLK_ERASE) | (opc_q == OP_CHIP_ERASE_A) |
      (opc_q == OP_CHIP_ERASE_B) | (opc_q == OP_SEC_ERASE);
   assign op_prog = (opc_q == OP_PROG) | (opc_q == OP_QPROG) |
      (opc_q == OP_SEC_PROG);
   // the read parameter header is reported once its byte is in
   assign fwd_now = cs_up & (state_q == ST_HOLD) & (op_wrsr |
      ((opc_q == OP_SET_PARAM) & (cnt_q >= PARAM_BITS)) |
      ((op_erase | op_prog) &
       ((opc_q == OP_CHIP_ERASE_A) | (opc_q == OP_CHIP_ERASE_B) |
        (cnt_q == ADDR_BITS))));
   assign blocked = sus_q & (op_wrsr |
      (susp_erase_q ? (op_erase | (opc_q == OP_SEC_PROG))
                    : (op_erase | op_prog)) |
      ((op_erase | op_prog) &
       (sh_q[SECT_MSB:SECT_LSB] == sus_sect_q)));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sus_q <= 1'b0;
         susp_erase_q <= 1'b0;
         sus_sect_q <= '0;
         lat_cnt_q <= 16'h0000;
         suspend_req <= 1'b0;
         resume_req <= 1'b0;
      end else begin
         suspend_req <= sus_ok;
         resume_req <= res_ok;
         if (sus_ok) begin
            sus_q <= 1'b1;
            susp_erase_q <= (op_kind != KIND_PAGE);
            sus_sect_q <= op_addr[SECT_MSB:SECT_LSB];
            lat_cnt_q <= 16'h0000;
         end else if (res_ok) begin
            sus_q <= 1'b0;
         end else if (sus_q && !lat_exp) begin
            lat_cnt_q <= lat_cnt_q + 16'h0001;
         end
      end
   end

   // busy is masked for the whole suspend; the engine may take up to the
   // suspend latency to halt, so its own running level is not trusted here
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         res_pend_q <= 1'b0;
      end else begin
         busy_q <= res_ok | res_pend_q |
            (engine_running & ~sus_q & ~lat_exp & ~sus_ok);
         if (res_ok) begin
            res_pend_q <= 1'b1;
         end else if (engine_running) begin
            res_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_valid <= 1'b0;
         cmd_refused <= 1'b0;
         cmd_opcode <= OP_NONE;
         cmd_addr <= 24'h000000;
      end else begin
         cmd_valid <= fwd_now & ~blocked;
         cmd_refused <= fwd_now & blocked;
         if (fwd_now) begin
            cmd_opcode <= opc_q;
            cmd_addr <= sh_q;
         end
      end
   end

   assign busy = busy_q;
   assign suspend_status_flag = sus_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_suspend;
      suspend_req ##0 suspend_status_flag;
   endsequence

   sequence s_resume;
      resume_req ##0 (busy && !suspend_status_flag);
   endsequence

   chk_susp_flag_set: assert property (
      suspend_req |-> suspend_status_flag && $past(!suspend_status_flag))
      else $error("suspend did not set the flag");
   chk_susp_busy_drop: assert property (
      s_suspend |-> ##[0:CHK_LAT] !busy)
      else $error("busy stayed high past suspend latency");
   chk_susp_gate: assert property (
      suspend_req |-> $past(busy) && $past(op_kind) != KIND_SECREG)
      else $error("suspend taken in a wrong state");
   chk_chip_no_susp: assert property (
      suspend_req |-> $past(op_kind) != KIND_CHIP)
      else $error("chip erase was suspended");
   chk_resume_gate: assert property (
      resume_req |-> $past(suspend_status_flag) && !$past(busy))
      else $error("resume taken in a wrong state");
   chk_resume_busy: assert property (
      $rose(res_pend_q) |-> s_resume ##[0:CHK_RES] busy)
      else $error("resume did not raise busy in time");
   chk_erase_susp_block: assert property (
      cmd_valid && sus_q && susp_erase_q |->
         !(op_erase || op_wrsr || cmd_opcode == OP_SEC_PROG))
      else $error("command let through in erase suspend");
   chk_prog_susp_block: assert property (
      cmd_valid && sus_q && !susp_erase_q |->
         !(op_erase || op_prog || op_wrsr))
      else $error("command let through in program suspend");
   chk_sector_guard: assert property (
      cmd_valid && sus_q && (op_erase || op_prog) |->
         cmd_addr[SECT_MSB:SECT_LSB] != sus_sect_q)
      else $error("suspended sector was addressed");
   chk_busy_read_ign: assert property (
      rd_busy_ign && sel |=> state_q == ST_IGN)
      else $error("read started while busy");
   chk_quad_enable: assert property (
      $rose(io_oe == 4'hF) && !quad_command_mode |->
         $past(quad_io_enable_bit, 1))
      else $error("quad read without quad enable");
   chk_dummy_count: assert property (
      state_q == ST_DUMMY && rise && sel |->
         cnt_q < dum_q ##1 (cnt_q <= dum_q))
      else $error("dummy count overran");
endmodule
`default_nettype wire

// file: bench/fsrr_host.sv
// Purpose: host controller model that drives the flash link pins
// Assumes: mode 0 link, link clock idle low, 8 ref_clk per link clock
// Notes: host lines are released outside its own drive phases
`timescale 1ns/1ps
`default_nettype none
module fsrr_host_model (
   input wire logic ref_clk,
   input wire logic [3:0] wire_io,
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic [3:0] host_io,
   output logic [3:0] host_oe
);
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      host_io = 4'h0;
      host_oe = 4'h0;
   end
   // one link clock; s is the wire just before the next fall, where
   // data launched on this fall has long settled
   task automatic tick(input logic [3:0] d, input logic [3:0] oe,
      output logic [3:0] s);
      sclk_pin = 1'b0;
      host_io = d;
      host_oe = oe;
      repeat (4) @(negedge ref_clk);
      sclk_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      s = wire_io;
   endtask
   task automatic shift(input logic [31:0] v, input int n, input int ln);
      logic [3:0] m;
      logic [3:0] s;
      m = 4'(2 ** ln - 1);
      for (int i = n - ln; i >= 0; i -= ln) begin
         tick(4'(v >> i) & m, m, s);
      end
   endtask
   task automatic idle(input int n);
      logic [3:0] s;
      repeat (n) tick(4'h0, 4'h0, s);
   endtask
   task automatic start();
      @(negedge ref_clk);
      cs_n_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic stop();
      sclk_pin = 1'b0;
      host_oe = 4'h0;
      repeat (4) @(negedge ref_clk);
      cs_n_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the suspend/resume and read interpreter
// Assumes: host model drives the link; engine and array modelled here
// Notes: suspend latency shortened through SUS_LAT_NS
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fsrr_pkg::*;
   localparam int SUS_LAT_NS = 1000;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n_pin, sclk_pin, suspend_req, resume_req, busy;
   logic suspend_status_flag, cmd_valid, cmd_refused;
   logic [3:0] io_out, io_oe, host_io, host_oe, wire_io;
   logic [3:0] flt = 4'h5;
   logic [23:0] mem_addr, cmd_addr;
   logic [7:0] mem_rdata, cmd_opcode;
   logic quad_io_enable_bit = 1'b0;
   logic quad_command_mode = 1'b0;
   logic engine_running = 1'b0;
   logic [2:0] op_kind = 3'h0;
   logic [23:0] op_addr = 24'h000000;
   logic [1:0] dummy_count_field;
   logic [4:0] g = 5'h00;
   int miscompares = 0;
   int compares = 0;
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) flt <= ~flt;
   // released lines toggle so a stale level never passes for data
   assign wire_io = (io_oe & io_out) | (~io_oe & host_oe & host_io) |
      (~io_oe & ~host_oe & flt);
   assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
   // pulses are one cycle wide, so they are caught in sticky bits
   always @(posedge ref_clk) begin
      g <= g | {io_oe != 4'h0, cmd_refused, cmd_valid, resume_req,
         suspend_req};
   end
   fsrr_cmd #(.SUS_LAT_NS(SUS_LAT_NS)) dut (.ref_clk, .rst, .cs_n_pin,
      .sclk_pin, .io_in(wire_io), .io_out, .io_oe, .mem_addr, .mem_rdata,
      .quad_io_enable_bit, .quad_command_mode, .engine_running, .op_kind,
      .op_addr, .suspend_req, .resume_req, .suspend_status_flag, .busy,
      .cmd_valid, .cmd_refused, .cmd_opcode, .cmd_addr,
      .dummy_count_field);
   fsrr_host_model host (.ref_clk, .wire_io, .cs_n_pin, .sclk_pin,
      .host_io, .host_oe);
   ////////////////////////////////////////////////////////////////////
   task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic [4:0] got, input logic [4:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [7:0] exp_byte(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   task automatic st(input logic ef, input logic eb);
      chk_flag({3'h0, suspend_status_flag, busy}, {3'h0, ef, eb});
   endtask
   // three-byte read; ok low means the device must stay silent
   task automatic rd(input logic [7:0] op, input logic [23:0] a,
      input int al, input int nd, input int dl, input logic ok);
      logic [3:0] s;
      logic [7:0] b;
      g = 5'h00;
      host.start();
      host.shift(32'(op), 8, quad_command_mode ? 4 : 1);
      host.shift(32'(a), 24, al);
      host.idle(nd);
      for (int n = 0; n < 3; n++) begin
         for (int k = 0; k < 8; k += dl) begin
            host.tick(4'h0, 4'h0, s);
            b = (dl == 1) ? {b[6:0], s[1]} :
               (dl == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
         end
         if (ok) chk_data(b, exp_byte(a + 24'(n)));
      end
      host.stop();
      chk_flag({4'h0, g[4]}, {4'h0, ok});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] v,
      input int n, input logic [4:0] exp);
      g = 5'h00;
      host.start();
      host.shift(32'(op), 8, quad_command_mode ? 4 : 1);
      host.shift(v, n, quad_command_mode ? 4 : 1);
      host.stop();
      chk_flag(g, exp);
      if (exp[2]) chk_data(cmd_opcode, op);
      // header address is the first 24 bits after the opcode
      if ((exp[2] || exp[3]) && n >= 24) begin
         chk_addr(cmd_addr, 24'(v >> (n - 24)));
      end
   endtask
   task automatic t_read();
      rd(OP_READ, 24'h0012FE, 1, 0, 1, 1'b1);
      engine_running = 1'b1;
      repeat (2) @(negedge ref_clk);
      rd(OP_READ, 24'h000100, 1, 0, 1, 1'b0);
      engine_running = 1'b0;
      $display("test read done");
   endtask
   task automatic t_fast();
      rd(OP_FAST, 24'h0A0B0C, 1, 8, 1, 1'b1);
      rd(OP_DUAL, 24'h001234, 1, 8, 2, 1'b1);
      rd(OP_QUAD, 24'h002345, 1, 8, 4, 1'b0);
      quad_io_enable_bit = 1'b1;
      rd(OP_QUAD, 24'h003456, 1, 8, 4, 1'b1);
      rd(OP_DUAL_IO, 24'h0456FF, 2, 4, 2, 1'b1);
      $display("test fast done");
   endtask
   task automatic t_qpi();
      quad_command_mode = 1'b1;
      chk_data({6'h00, dummy_count_field}, 8'h00);
      rd(OP_FAST, 24'h00ABCD, 4, 4, 4, 1'b1);
      cmd(OP_SET_PARAM, 32'h10, 8, 5'h04);
      chk_data({6'h00, dummy_count_field}, 8'h01);
      rd(OP_FAST, 24'h00BCDE, 4, 6, 4, 1'b1);
      cmd(OP_SET_PARAM, 32'h20, 8, 5'h04);
      rd(OP_FAST, 24'h00CDEF, 4, 8, 4, 1'b1);
      quad_command_mode = 1'b0;
      $display("test qpi done");
   endtask
   task automatic t_sus();
      engine_running = 1'b1;
      op_kind = KIND_SECTOR;
      op_addr = 24'h045000;
      repeat (2) @(negedge ref_clk);
      st(1'b0, 1'b1);
      cmd(OP_SUSPEND, 0, 0, 5'h01);
      st(1'b1, 1'b0);
      cmd(OP_SUSPEND, 0, 0, 5'h00);
      cmd(OP_SECT_ERASE, 32'h080000, 24, 5'h08);
      cmd(OP_SEC_ERASE, 32'h001000, 24, 5'h08);
      cmd(OP_WRSR_A, 32'h00, 8, 5'h08);
      cmd(OP_PROG, 32'h080000FF, 32, 5'h04);
      cmd(OP_PROG, 32'h045010FF, 32, 5'h08);
      rd(OP_READ, 24'h090000, 1, 0, 1, 1'b1);
      cmd(OP_RESUME, 0, 0, 5'h02);
      st(1'b0, 1'b1);
      cmd(OP_RESUME, 0, 0, 5'h00);
      repeat (SUS_LAT_NS / 100) @(negedge ref_clk);
      op_kind = KIND_CHIP;
      cmd(OP_SUSPEND, 0, 0, 5'h00);
      op_kind = KIND_SECREG;
      cmd(OP_SUSPEND, 0, 0, 5'h00);
      op_kind = KIND_PAGE;
      cmd(OP_SUSPEND, 0, 0, 5'h01);
      cmd(OP_QPROG, 32'h120000FF, 32, 5'h08);
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      st(1'b0, 1'b1);
      engine_running = 1'b0;
      $display("test suspend done");
   endtask
   initial begin
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_read();
      t_fast();
      t_qpi();
      t_sus();
      end_sim();
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      miscompares++;
      end_sim();
   end
endmodule
`default_nettype wire
